// File: logic/regulator_core.v
`include "regulator_defs.vh"
module regulator_core #(
  parameter integer TICK_CYCLES = `REG_SAMPLE_CYCLES
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // control method
  input wire [1:0] controlMethodSelect,
  input wire [7:0] manualTorqueBoost,
  output reg sensorlessMode,
  output reg autoBoostEn,
  output reg slipCompEn,
  output reg [7:0] torqueBoostApplied,
  // regulator settings
  input wire regulatorEnableSelect,
  input wire regulatorModeSelect,
  input wire regulatorUnitSelect,
  input wire [1:0] feedbackSourceSelect,
  input wire [2:0] setpointSourceSelect,
  input wire [15:0] setpointValue,
  input wire [13:0] proportionalGain,
  input wire [11:0] integralTime,
  input wire [11:0] derivativeTime,
  input wire [15:0] outputUpperLimit,
  input wire [15:0] outputLowerLimit,
  input wire [15:0] maximumFrequency,
  input wire [15:0] mainFrequencyRef,
  input wire [14:0] sleepDelayTime,
  input wire [15:0] sleepFrequency,
  input wire [9:0] wakeLevel,
  input wire [4:0] inputTerminalFunction,
  // pins
  input wire terminalPin,
  input wire runCmdPin,
  // analog converters, same clock
  input wire [11:0] firstVoltageInput,
  input wire [11:0] secondAnalogCurrent,
  input wire [11:0] secondAnalogVoltage,
  // serial link register port
  input wire linkWrEn,
  input wire [15:0] linkAddr,
  input wire [15:0] linkWrData,
  output reg [15:0] linkRdData,
  // results
  output reg [15:0] outputFrequency,
  output reg [16:0] innerRegulatorOutput,
  output reg [15:0] summedFrequencyOutput,
  output reg [15:0] feedbackValue,
  output reg [15:0] monitorValue,
  output reg sleepActive,
  output reg bypassActive
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // 0.1 percent to 0.01 Hz against maximum frequency
  function [15:0] pctToFreq;
    input [15:0] pct;
    input [15:0] maxF;
    reg [31:0] prod;
    reg [31:0] quot;
    begin
      prod = pct * maxF;
      quot = prod / `PERCENT_FULL_SCALE;
      pctToFreq = quot[15:0];
    end
  endfunction

  // converter code scaled to a full-scale value
  function [15:0] adcScale;
    input [11:0] code;
    input [15:0] full;
    reg [31:0] prod;
    reg [31:0] quot;
    begin
      prod = code * full;
      quot = prod / `ADC_FULL_SCALE;
      adcScale = quot[15:0];
    end
  endfunction

  function signed [39:0] clampS;
    input signed [39:0] v;
    input signed [39:0] lo;
    input signed [39:0] hi;
    begin
      if (v > hi) clampS = hi;
      else if (v < lo) clampS = lo;
      else clampS = v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // tick and pins

  wire tick;
  wire [1:0] pinsSync;
  wire bypassPin = pinsSync[0];
  wire running = pinsSync[1];

  regulator_tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  regulator_pin_sync #(.WIDTH(2)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinIn({runCmdPin, terminalPin}),
    .pinOut(pinsSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control method and link register

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sensorlessMode <= 1'b0;
      autoBoostEn <= 1'b0;
      slipCompEn <= 1'b0;
      torqueBoostApplied <= 8'h00;
    end else begin
      sensorlessMode <= (controlMethodSelect == `METHOD_SENSORLESS);
      autoBoostEn <= (controlMethodSelect == `METHOD_SENSORLESS);
      slipCompEn <= (controlMethodSelect == `METHOD_SENSORLESS) ||
                    (controlMethodSelect == `METHOD_SLIP_COMP);
      torqueBoostApplied <= (controlMethodSelect == `METHOD_SENSORLESS) ?
                            8'h00 : manualTorqueBoost;
    end
  end

  reg [15:0] linkFeedback_ff;
  wire linkHit = (linkAddr == `FEEDBACK_LINK_ADDR);

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      linkFeedback_ff <= 16'h0000;
      linkRdData <= 16'h0000;
    end else begin
      if (linkWrEn && linkHit)
        linkFeedback_ff <= (linkWrData > `PERCENT_FULL_SCALE) ?
                           16'h03E8 : linkWrData;
      linkRdData <= linkHit ? linkFeedback_ff : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // setpoint and feedback, all internal math in 0.01 Hz

  reg [15:0] spFreq;
  reg [15:0] fbFreq;
  reg [15:0] fbUnit;

  always @* begin
    case (setpointSourceSelect)
      `SP_SRC_FIRST_VOLTAGE: spFreq = adcScale(firstVoltageInput, maximumFrequency);
      `SP_SRC_SECOND_CURRENT: spFreq = adcScale(secondAnalogCurrent, maximumFrequency);
      `SP_SRC_SECOND_VOLTAGE: spFreq = adcScale(secondAnalogVoltage, maximumFrequency);
      `SP_SRC_LINK: spFreq = pctToFreq(linkFeedback_ff, maximumFrequency);
      default: spFreq = regulatorUnitSelect ?
                        pctToFreq(setpointValue, maximumFrequency) : setpointValue;
    endcase
    case (feedbackSourceSelect)
      `FB_SRC_SECOND_CURRENT: begin
        fbFreq = adcScale(secondAnalogCurrent, maximumFrequency);
        fbUnit = regulatorUnitSelect ?
                 adcScale(secondAnalogCurrent, 16'h03E8) : fbFreq;
      end
      `FB_SRC_SECOND_VOLTAGE: begin
        fbFreq = adcScale(secondAnalogVoltage, maximumFrequency);
        fbUnit = regulatorUnitSelect ? adcScale(secondAnalogVoltage, 16'h03E8) : fbFreq;
      end
      `FB_SRC_FIRST_VOLTAGE: begin
        fbFreq = adcScale(firstVoltageInput, maximumFrequency);
        fbUnit = regulatorUnitSelect ? adcScale(firstVoltageInput, 16'h03E8) : fbFreq;
      end
      default: begin
        fbFreq = pctToFreq(linkFeedback_ff, maximumFrequency);
        fbUnit = regulatorUnitSelect ? linkFeedback_ff : fbFreq;
      end
    endcase
  end

  wire regOn = regulatorEnableSelect;
  wire bypassReq = (inputTerminalFunction == `BYPASS_FUNCTION_CODE) && bypassPin;
  wire signed [39:0] errNow = $signed({24'h0, spFreq}) - $signed({24'h0, fbFreq});

  ////////////////////////////////////////////////////////////////////////////
  // sampled terms

  reg signed [39:0] err_ff;
  reg signed [39:0] errPrev_ff;
  reg signed [39:0] acc_ff;
  reg [21:0] sleepCount_ff;
  wire clearInt = !regOn || bypassReq || sleepActive || !running;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_ff <= 40'sh0;
      errPrev_ff <= 40'sh0;
      acc_ff <= 40'sh0;
    end else if (clearInt) begin
      acc_ff <= 40'sh0;
      err_ff <= 40'sh0;
      errPrev_ff <= 40'sh0;
    end else if (tick) begin
      errPrev_ff <= err_ff;
      err_ff <= errNow;
      acc_ff <= clampS(acc_ff + errNow, -40'sh10000000, 40'sh10000000);
    end
  end

  wire signed [39:0] kp = $signed({26'h0, proportionalGain});
  wire signed [39:0] tiMs = $signed({28'h0, integralTime}) * `MS_PER_ITIME_UNIT;
  wire signed [39:0] tdMs = $signed({28'h0, derivativeTime}) * `MS_PER_ITIME_UNIT;
  wire signed [39:0] pTerm = (err_ff * kp) / `GAIN_FULL_SCALE;
  wire signed [39:0] iTerm = (tiMs == 40'sh0) ? 40'sh0 : acc_ff / tiMs;
  wire signed [39:0] dTerm = (err_ff - errPrev_ff) * tdMs;
  wire signed [39:0] pidSum = pTerm + iTerm + dTerm;
  wire signed [39:0] upper = $signed({24'h0, outputUpperLimit});
  wire signed [39:0] lower = $signed({24'h0, outputLowerLimit});
  wire signed [39:0] maxF = $signed({24'h0, maximumFrequency});
  wire signed [39:0] mainRef = $signed({24'h0, mainFrequencyRef});

  ////////////////////////////////////////////////////////////////////////////
  // output selection

  reg signed [39:0] inner;
  reg signed [39:0] summed;
  reg signed [39:0] outSel;

  always @* begin
    if (regulatorModeSelect) begin
      inner = clampS(pidSum, -upper, upper);
      summed = clampS(mainRef + inner, lower, maxF);
    end else begin
      inner = clampS(pidSum, lower, upper);
      summed = inner;
    end
    // a stopped drive outputs nothing, whatever the regulator settings
    if (!running)
      outSel = 40'sh0;
    else if (!regOn)
      outSel = mainRef;
    else if (bypassReq && regulatorModeSelect)
      outSel = mainRef;
    else if (bypassReq)
      outSel = $signed({24'h0, spFreq});
    else if (sleepActive)
      outSel = 40'sh0;
    else
      outSel = summed;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep and wake

  wire [31:0] sleepProd = sleepDelayTime * `MS_PER_SLEEP_UNIT;
  wire [21:0] sleepLimit = sleepProd[21:0];
  wire [15:0] deviation = (spFreq > fbFreq) ? spFreq - fbFreq : fbFreq - spFreq;
  wire [31:0] devScaled = deviation * `PERCENT_FULL_SCALE;
  wire [31:0] wakeScaled = wakeLevel * maximumFrequency;
  wire atSleepFreq = (summed[15:0] <= sleepFrequency);

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleepActive <= 1'b0;
      sleepCount_ff <= 22'h0;
    end else if (!running || !regOn || bypassReq) begin
      sleepActive <= 1'b0;
      sleepCount_ff <= 22'h0;
    end else if (sleepActive) begin
      if (devScaled > wakeScaled)
        sleepActive <= 1'b0;
      sleepCount_ff <= 22'h0;
    end else if (!atSleepFreq) begin
      sleepCount_ff <= 22'h0;
    end else if (sleepCount_ff >= sleepLimit) begin
      sleepActive <= 1'b1;
    end else if (tick) begin
      sleepCount_ff <= sleepCount_ff + 22'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered results

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outputFrequency <= 16'h0000;
      innerRegulatorOutput <= 17'h00000;
      summedFrequencyOutput <= 16'h0000;
      feedbackValue <= 16'h0000;
      monitorValue <= 16'h0000;
      bypassActive <= 1'b0;
    end else begin
      outputFrequency <= outSel[15:0];
      innerRegulatorOutput <= inner[16:0];
      summedFrequencyOutput <= summed[15:0];
      feedbackValue <= fbUnit;
      monitorValue <= bypassReq ? outSel[15:0] : fbUnit;
      bypassActive <= bypassReq && regOn;
    end
  end

endmodule // regulator_core

// File: logic/regulator_defs.vh
// Functional notes
// - control method 2 selects simple sensorless: auto start torque and slip compensation
// - in simple sensorless mode the manual torque boost has no effect
// - regulator and its settings act only when enable select is 1; at 0 the bypass input still switches the monitor to output frequency
// - mode select 0 is normal regulation, 1 is process regulation
// - feedback source: 0 second input current, 1 second input voltage, 2 first voltage, 3 link
// - unit select 0 is hertz, 1 is percent; feedback follows setpoint unit
// - link master writes feedback at address 0x001E in 0.1 percent steps
// - proportional term is error times gain percentage
// - constant full error gives full output after the integral time
// - error sampled and terms updated once per millisecond
// - derivative term is error change rate times derivative time
// - output clamped between upper and lower limits, default 60.00 and 0.50 Hz
// - input with function code 21 asserted bypasses regulation
// - bypass in percent units converts percent to frequency, 100.0 percent is maximum
// - normal mode output is unipolar and within upper and lower limits
// - process mode output is main reference plus regulator output
// - process inner output bipolar within upper limit; sum within maximum and lower limit
// - process mode with bypass outputs the main reference alone
// - sleep after output stays at sleep frequency for the sleep delay, default 60.0 s
// - in sleep, wake when deviation exceeds wake level, default 35.0 percent
// - stop command cancels sleep so no automatic wake after stop
// - during bypass the monitor shows output frequency, not feedback
`ifndef REGULATOR_DEFS_VH
`define REGULATOR_DEFS_VH
`define CORE_CLK_PERIOD_NS 5
`define REG_SAMPLE_PERIOD_NS 1000000
`define REG_SAMPLE_CYCLES (`REG_SAMPLE_PERIOD_NS / `CORE_CLK_PERIOD_NS)
`define FEEDBACK_LINK_ADDR 16'h001E
`define METHOD_SENSORLESS 2'h2
`define METHOD_SLIP_COMP 2'h1
`define FB_SRC_SECOND_CURRENT 2'h0
`define FB_SRC_SECOND_VOLTAGE 2'h1
`define FB_SRC_FIRST_VOLTAGE 2'h2
`define FB_SRC_LINK 2'h3
`define SP_SRC_FIRST_VOLTAGE 3'h2
`define SP_SRC_SECOND_CURRENT 3'h3
`define SP_SRC_SECOND_VOLTAGE 3'h4
`define SP_SRC_LINK 3'h5
`define BYPASS_FUNCTION_CODE 5'h15
`define PERCENT_FULL_SCALE 1000
`define ADC_FULL_SCALE 4095
`define GAIN_FULL_SCALE 1000
`define MS_PER_ITIME_UNIT 10
`define MS_PER_SLEEP_UNIT 100
`define UPPER_LIMIT_RESET 16'h1770
`define LOWER_LIMIT_RESET 16'h0032
`define SLEEP_DELAY_RESET 15'h0258
`define WAKE_LEVEL_RESET 10'h15E
`endif

// File: logic/regulator_tick_divider.v
`include "regulator_defs.vh"
module regulator_tick_divider #(
  parameter integer CYCLES = `REG_SAMPLE_CYCLES
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // one-cycle enable every CYCLES clocks
  output reg tick
);
  reg [31:0] count_ff;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= 32'h0;
      tick <= 1'b0;
    end else if (count_ff == CYCLES - 1) begin
      count_ff <= 32'h0;
      tick <= 1'b1;
    end else begin
      count_ff <= count_ff + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // regulator_tick_divider

// File: logic/regulator_pin_sync.v
module regulator_pin_sync #(
  parameter integer WIDTH = 2
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // asynchronous pins and their synchronised copies
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinOut
);
  reg [WIDTH-1:0] meta_ff;

  // first stage feeds only the second
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= {WIDTH{1'b0}};
      pinOut <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= pinIn;
      pinOut <= meta_ff;
    end
  end
endmodule // regulator_pin_sync

// File: verif/regulator_core_chk.sv
module regulator_core_chk (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // settings and pins
  input wire [1:0] controlMethodSelect,
  input wire regulatorEnableSelect,
  input wire regulatorModeSelect,
  input wire [15:0] outputUpperLimit,
  input wire [15:0] outputLowerLimit,
  input wire [15:0] mainFrequencyRef,
  input wire runCmdPin,
  input wire [15:0] linkAddr,
  // results
  input wire sensorlessMode,
  input wire slipCompEn,
  input wire [7:0] torqueBoostApplied,
  input wire [15:0] linkRdData,
  input wire [15:0] outputFrequency,
  input wire [16:0] innerRegulatorOutput,
  input wire [15:0] monitorValue,
  input wire sleepActive,
  input wire bypassActive
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_SENSORLESS:
    assert property ((controlMethodSelect == 2'h2) [*3] |-> sensorlessMode && slipCompEn)
    else $error("sensorless flags low");
  AST_BOOST_OFF:
    assert property ((controlMethodSelect == 2'h2) [*2] |-> torqueBoostApplied == 8'h00)
    else $error("boost applied in sensorless");
  AST_LINK_REFUSE:
    assert property (linkAddr != 16'h001E |=> linkRdData == 16'h0000)
    else $error("read data at other address");
  AST_NORMAL_LIMIT:
    assert property ((regulatorEnableSelect && !regulatorModeSelect && !bypassActive) [*3]
      ##0 outputFrequency != 16'h0000
      |-> outputFrequency >= outputLowerLimit && outputFrequency <= outputUpperLimit)
    else $error("normal output outside limits");
  AST_INNER_BOUND:
    assert property ((regulatorEnableSelect && regulatorModeSelect) [*3]
      |-> $signed(innerRegulatorOutput) <= $signed({1'b0, outputUpperLimit})
      && $signed(innerRegulatorOutput) >= -$signed({1'b0, outputUpperLimit}))
    else $error("inner output outside limit");
  AST_PROC_BYPASS:
    assert property ((regulatorEnableSelect && regulatorModeSelect && bypassActive && runCmdPin
      && !sleepActive && $stable(mainFrequencyRef)) [*4] |-> outputFrequency == mainFrequencyRef)
    else $error("process bypass not main reference");
  AST_MONITOR:
    assert property ((bypassActive && $stable(outputFrequency)) [*2]
      |-> monitorValue == outputFrequency)
    else $error("monitor not output in bypass");
  AST_STOP_SLEEP:
    assert property ((!runCmdPin) [*4] |-> !sleepActive && outputFrequency == 16'h0000)
    else $error("asleep or running after stop");
  cover property (bypassActive);
  cover property (sleepActive);
  cover property (regulatorModeSelect && innerRegulatorOutput[16]);
endmodule // regulator_core_chk

// File: verif/link_master_model.sv
module link_master_model (
  // clock
  input wire core_clk,
  // requests from the bench
  input wire wrReq,
  input wire [15:0] reqAddr,
  input wire [15:0] reqData,
  // link side
  output reg linkWrEn,
  output reg [15:0] linkAddr,
  output reg [15:0] linkWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    linkWrEn = 1'b0;
    linkAddr = 16'h001E;
    linkWrData = 16'h0000;
  end
  // data toggles outside writes so a stale value is never mistaken for valid
  always @(posedge core_clk) begin
    linkWrEn <= wrReq;
    linkAddr <= reqAddr;
    linkWrData <= wrReq ? reqData : ~linkWrData;
  end
endmodule // link_master_model

// File: verif/drive_pid_speed_regulator_test.sv
module drive_pid_speed_regulator_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer T = 20;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [1:0] controlMethodSelect = 2'h0;
  reg [7:0] manualTorqueBoost = 8'h00;
  reg regulatorEnableSelect = 1'b0;
  reg regulatorModeSelect = 1'b0;
  reg regulatorUnitSelect = 1'b1;
  reg [1:0] feedbackSourceSelect = 2'h3;
  reg [2:0] setpointSourceSelect = 3'h0;
  reg [15:0] setpointValue = 16'h0000;
  reg [13:0] proportionalGain = 14'h270F;
  reg [11:0] integralTime = 12'h064;
  reg [11:0] derivativeTime = 12'h000;
  reg [15:0] outputUpperLimit = 16'h1770;
  reg [15:0] outputLowerLimit = 16'h0032;
  reg [15:0] maximumFrequency = 16'h1770;
  reg [15:0] mainFrequencyRef = 16'h0BB8;
  reg [14:0] sleepDelayTime = 15'h0258;
  reg [15:0] sleepFrequency = 16'h0000;
  reg [9:0] wakeLevel = 10'h3E8;
  reg [4:0] inputTerminalFunction = 5'h00;
  reg terminalPin = 1'b0;
  reg runCmdPin = 1'b0;
  reg [11:0] firstVoltageInput = 12'h000;
  reg [11:0] secondAnalogCurrent = 12'h000;
  reg [11:0] secondAnalogVoltage = 12'h000;
  reg wrReq = 1'b0;
  reg [15:0] reqAddr = 16'h001E;
  reg [15:0] reqData = 16'h0000;
  wire linkWrEn, sensorlessMode, autoBoostEn, slipCompEn, sleepActive, bypassActive;
  wire [15:0] linkAddr, linkWrData, linkRdData, outputFrequency;
  wire [15:0] summedFrequencyOutput, feedbackValue, monitorValue;
  wire [7:0] torqueBoostApplied;
  wire [16:0] innerRegulatorOutput;
  integer badCount = 0;
  integer nChecks = 0;
  integer cyc = 0;
  regulator_core #(.TICK_CYCLES(T)) dut (.*);
  link_master_model partner (.*);
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      badCount = badCount + 1;
      tallyAndFinish;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input [16:0] seen, input [16:0] want);
    nChecks = nChecks + 1;
    if (seen !== want) begin
      badCount = badCount + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic step(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic linkWr(input [15:0] a, input [15:0] d);
    @(posedge core_clk);
    wrReq <= 1'b1;
    reqAddr <= a;
    reqData <= d;
    @(posedge core_clk);
    wrReq <= 1'b0;
    reqAddr <= 16'h001E;
    step(3);
  endtask
  // setpoint and link feedback, then let the loop settle
  task automatic drive(input [15:0] sp, input [15:0] fb);
    @(posedge core_clk);
    setpointValue <= sp;
    linkWr(16'h001E, fb);
    step(6 * T);
  endtask
  task automatic tallyAndFinish;
    if (badCount == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tMethod;
    for (int m = 0; m < 3; m++) begin
      @(posedge core_clk);
      controlMethodSelect <= m[1:0];
      manualTorqueBoost <= 8'h5A + m[7:0];
      step(3);
      chk(sensorlessMode, m == 2);
      chk(autoBoostEn, m == 2);
      chk(slipCompEn, m != 0);
      chk(torqueBoostApplied, (m == 2) ? 8'h00 : 8'h5A + m[7:0]);
    end
  endtask
  task automatic tLink;
    linkWr(16'h001E, 16'h01F4);
    chk(linkRdData, 16'h01F4);
    linkWr(16'h001F, 16'h0064);
    chk(linkRdData, 16'h01F4);
    linkWr(16'h001E, 16'h05DC);
    chk(linkRdData, 16'h03E8);
    @(posedge core_clk);
    reqAddr <= 16'h0010;
    step(3);
    chk(linkRdData, 16'h0000);
    reqAddr <= 16'h001E;
    step(2 * T);
    chk(feedbackValue, 16'h03E8);
  endtask
  task automatic tSources;
    for (int s = 0; s < 3; s++) begin
      @(posedge core_clk);
      feedbackSourceSelect <= s[1:0];
      secondAnalogCurrent <= (s == 0) ? 12'hFFF : 12'h000;
      secondAnalogVoltage <= (s == 1) ? 12'hFFF : 12'h000;
      firstVoltageInput <= (s == 2) ? 12'hFFF : 12'h000;
      regulatorUnitSelect <= 1'b1;
      step(2 * T);
      chk(feedbackValue, 16'h03E8);
      regulatorUnitSelect <= 1'b0;
      step(2 * T);
      chk(feedbackValue, 16'h1770);
    end
    regulatorUnitSelect <= 1'b1;
    feedbackSourceSelect <= 2'h3;
  endtask
  task automatic tNormal;
    regulatorEnableSelect <= 1'b1;
    runCmdPin <= 1'b1;
    drive(16'h03E8, 16'h0000);
    chk(outputFrequency, 16'h1770);
    drive(16'h0000, 16'h03E8);
    chk(outputFrequency, 16'h0032);
    regulatorEnableSelect <= 1'b0;
    step(5);
    chk(outputFrequency, 16'h0BB8);
    regulatorEnableSelect <= 1'b1;
  endtask
  task automatic tProcess;
    @(posedge core_clk);
    regulatorModeSelect <= 1'b1;
    outputUpperLimit <= 16'h03E8;
    drive(16'h03E8, 16'h0000);
    chk(innerRegulatorOutput, 17'h003E8);
    chk(outputFrequency, 16'h0FA0);
    drive(16'h0000, 16'h03E8);
    chk(innerRegulatorOutput, 17'h1FC18);
    chk(summedFrequencyOutput, 16'h07D0);
    regulatorModeSelect <= 1'b0;
    outputUpperLimit <= 16'h1770;
  endtask
  task automatic tBypass;
    @(posedge core_clk);
    terminalPin <= 1'b1;
    setpointValue <= 16'h0190;
    step(6);
    chk(bypassActive, 1'b0);
    inputTerminalFunction <= 5'h15;
    step(6);
    chk(bypassActive, 1'b1);
    chk(outputFrequency, 16'h0960);
    chk(monitorValue, 16'h0960);
    setpointSourceSelect <= 3'h2;
    step(4);
    chk(outputFrequency, 16'h1770);
    setpointSourceSelect <= 3'h0;
    regulatorModeSelect <= 1'b1;
    mainFrequencyRef <= 16'h0456;
    step(6);
    chk(outputFrequency, 16'h0456);
    regulatorModeSelect <= 1'b0;
    terminalPin <= 1'b0;
  endtask
  // one term at a time; disabling first clears the accumulator
  task automatic tGains;
    reg [15:0] first;
    @(posedge core_clk);
    regulatorEnableSelect <= 1'b0;
    proportionalGain <= 14'h01F4;
    integralTime <= 12'hFFF;
    step(3);
    regulatorEnableSelect <= 1'b1;
    drive(16'h01F4, 16'h0064);
    chk(outputFrequency, 16'h04B0);
    proportionalGain <= 14'h0000;
    integralTime <= 12'h001;
    step(2 * T);
    first = outputFrequency;
    step(5 * T);
    chk(outputFrequency, first + 16'h04B0);
    regulatorEnableSelect <= 1'b0;
    linkWr(16'h001E, 16'h01F4);
    regulatorEnableSelect <= 1'b1;
    step(3 * T);
    chk(outputFrequency, 16'h0032);
    derivativeTime <= 12'h001;
    integralTime <= 12'hFFF;
    linkWr(16'h001E, 16'h01C2);
    for (int i = 0; i < 3 * T && outputFrequency == 16'h0032; i++) step(1);
    chk(outputFrequency, 16'h0BB8);
    proportionalGain <= 14'h270F;
    derivativeTime <= 12'h000;
    integralTime <= 12'h064;
  endtask
  task automatic tSleep;
    @(posedge core_clk);
    sleepDelayTime <= 15'h0001;
    sleepFrequency <= 16'h0032;
    drive(16'h0000, 16'h03E8);
    step(70 * T);
    chk(sleepActive, 1'b0);
    step(40 * T);
    chk(sleepActive, 1'b1);
    chk(outputFrequency, 16'h0000);
    wakeLevel <= 10'h000;
    step(6);
    chk(sleepActive, 1'b0);
    wakeLevel <= 10'h3E8;
    step(120 * T);
    runCmdPin <= 1'b0;
    step(6);
    chk(sleepActive, 1'b0);
    chk(outputFrequency, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    step(3);
    tMethod;
    tLink;
    tSources;
    tNormal;
    tProcess;
    tBypass;
    tGains;
    tSleep;
    tallyAndFinish;
  end
endmodule // drive_pid_speed_regulator_test

bind regulator_core regulator_core_chk chk (.*);
